// ==== core/bus_pins_pkg.sv ====
// Constants, register map and carrier types of the bus pin unit.
// Assumes a single 50 MHz core clock and an APB register port.
//
// Summary of operation
// - Status 000 inta, 001 io rd, 010 io wr, 011 halt
// - Status 100 fetch, 101 mem rd, 110 mem wr, 111 passive
// - Status pins float during bus hold
// - DMA flag high in later cycle periods
// - DMA flag floats in hold and reset
// - Halving strap low at reset halves clock
// - Sync ready sampled without extra half stage
// - Sync ready high readies; low defers to async
// - Timer counts on synchronised rising input edges
// - Demod mode feeds both timers from demod input
// - Timer input held high when pin is gpio
// - Timer outputs pulse or waveform, float in hold/reset
// - Upper select covers F0000h 64K after reset
// - Upper block base and size programmable, 512K max
// - Upper select released, pulled high, during hold
// - Bank1 row strobe disables upper select permanently
// - Both isolation straps low float all pins except bus clock, bank1 row strobe and upper zero flag
// - Upper zero flag is NOR of A19-A16, whole cycle
// - High write enable is high enable OR strobe
// - Low write enable is address bit0 OR strobe
// - Write strobe on writes, floats in hold/reset
package bus_pins_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] UPPER_OFFSET = 8'h04;
  localparam logic [7:0] TMR0_OFFSET = 8'h08;
  localparam logic [7:0] TMR1_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] COUNT_OFFSET = 8'h14;

  localparam int CTRL_PWD_BIT = 0;
  localparam int CTRL_GPIO11_BIT = 1;
  localparam int CTRL_GPIO0_BIT = 2;
  localparam int CTRL_BANK1_BIT = 3;
  localparam int CTRL_TEN_LSB = 4;
  localparam int CTRL_TCONT_LSB = 6;
  localparam int UPPER_SIZE_LSB = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] UPPER_BASE_RESET = 4'hf;
  localparam logic [1:0] UPPER_SIZE_RESET = 2'h0;
  localparam logic [31:0] TMR_RESET = 32'h0000_0000;

  // ==========================================================
  // Bus cycle status codes
  localparam logic [2:0] ST_INTA = 3'h0;
  localparam logic [2:0] ST_IO_RD = 3'h1;
  localparam logic [2:0] ST_IO_WR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MEM_RD = 3'h5;
  localparam logic [2:0] ST_MEM_WR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;

  // ==========================================================
  // Bus clock half periods, in core cycles minus one
  localparam logic [1:0] BUSCLK_HALF_NORMAL = 2'h0;
  localparam logic [1:0] BUSCLK_HALF_HALVED = 2'h1;

  typedef enum {BUS_IDLE, BUS_T1, BUS_T2, BUS_T3, BUS_T4} bus_state_t;

  typedef struct packed {
    logic [2:0] kind;
    logic [19:0] addr;
    logic high_byte_enable_n;
    logic dma;
  } cycle_req_t;

endpackage

// ==== core/bus_pins.sv ====
// Bus pin unit: cycle status, strobes, chip select, straps, timers.
// Assumes the core hands over one cycle request at a time and that
// pin pulls and tri-state wires are resolved outside.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bus_pins (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bus_pins_pkg::cycle_req_t cyc_req,
  input wire logic cyc_valid,
  output logic cyc_ready,
  input wire logic hold_request,
  output logic hold_ack,
  input wire logic sync_ready_input,
  input wire logic async_ready_input,
  input wire logic clock_halving_strap,
  input wire logic isolation_request_a,
  input wire logic isolation_request_b,
  input wire logic timer0_input,
  input wire logic timer1_input,
  input wire logic pulse_demod_input,
  output logic bus_clock_output,
  output logic clock_halving_mode,
  output logic pin_isolation_mode,
  output logic [2:0] bus_cycle_status,
  output logic bus_cycle_status_oe,
  output logic dma_cycle_flag,
  output logic dma_cycle_flag_oe,
  output logic upper_memory_select_n,
  output logic upper_memory_select_oe,
  output logic dram_bank1_row_strobe_n,
  output logic upper_zero_flag_n,
  output logic high_byte_write_enable_n,
  output logic low_byte_write_enable_n,
  output logic write_strobe_n,
  output logic strobe_oe,
  output logic [1:0] timer_output,
  output logic [1:0] timer_output_oe
);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_r;
  logic rst_n_sync;
  logic [1:0] hold_s_r, async_ready_input_s_r, pd_s_r, half_s_r, isoa_s_r, isob_s_r;
  logic sync_ready_input_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_r[1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_sync);

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      hold_s_r <= 2'h0;
      async_ready_input_s_r <= 2'h0;
      // Idle level of the pulled-up pin, so no false edge after reset
      pd_s_r <= 2'h3;
      sync_ready_input_r <= 1'b0;
    end else begin
      hold_s_r <= {hold_s_r[0], hold_request};
      async_ready_input_s_r <= {async_ready_input_s_r[0], async_ready_input};
      pd_s_r <= {pd_s_r[0], pulse_demod_input};
      // Aligned to the bus clock, so one stage only
      sync_ready_input_r <= sync_ready_input;
    end
  end

  // ==========================================================
  // Straps, caught once after the reset release
  logic strap_done_r;
  // No reset: the pipes fill while reset is held, so the value caught
  // at the release is the strap level and not a reset constant
  always_ff @(posedge core_clk) begin
    half_s_r <= {half_s_r[0], clock_halving_strap};
    isoa_s_r <= {isoa_s_r[0], isolation_request_a};
    isob_s_r <= {isob_s_r[0], isolation_request_b};
  end
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      strap_done_r <= 1'b0;
      clock_halving_mode <= 1'b0;
      pin_isolation_mode <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      clock_halving_mode <= !half_s_r[1];
      pin_isolation_mode <= !isoa_s_r[1] && !isob_s_r[1];
    end
  end

  // ==========================================================
  // Bus clock divider; no PLL here, halving doubles the period
  logic [1:0] div_cnt_r;
  logic [1:0] half_lim;
  logic bus_tick;
  assign half_lim = clock_halving_mode ? bus_pins_pkg::BUSCLK_HALF_HALVED
                                       : bus_pins_pkg::BUSCLK_HALF_NORMAL;
  assign bus_tick = (div_cnt_r == half_lim) && !bus_clock_output;
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      div_cnt_r <= 2'h0;
      bus_clock_output <= 1'b0;
    end else if (div_cnt_r == half_lim) begin
      div_cnt_r <= 2'h0;
      bus_clock_output <= !bus_clock_output;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end

  // ==========================================================
  // APB registers
  logic [7:0] ctrl_r;
  logic [3:0] upper_base_r;
  logic [1:0] upper_size_r;
  logic [31:0] tmr_cfg_r [2];
  logic [15:0] tmr_cnt_r [2];
  logic bank1_on_r;
  logic apb_setup, apb_write, addr_ok;
  bus_pins_pkg::bus_state_t state_r;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;
  assign addr_ok = paddr inside {bus_pins_pkg::CTRL_OFFSET,
    bus_pins_pkg::UPPER_OFFSET, bus_pins_pkg::TMR0_OFFSET,
    bus_pins_pkg::TMR1_OFFSET, bus_pins_pkg::STATUS_OFFSET,
    bus_pins_pkg::COUNT_OFFSET};

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      prdata <= 32'h0000_0000;
      if (apb_setup && !pwrite) begin
        case (paddr)
          bus_pins_pkg::CTRL_OFFSET: prdata <= {24'h0, ctrl_r};
          bus_pins_pkg::UPPER_OFFSET:
            prdata <= {26'h0, upper_size_r, upper_base_r};
          bus_pins_pkg::TMR0_OFFSET: prdata <= tmr_cfg_r[0];
          bus_pins_pkg::TMR1_OFFSET: prdata <= tmr_cfg_r[1];
          bus_pins_pkg::STATUS_OFFSET:
            prdata <= {26'h0, bank1_on_r, pin_isolation_mode,
                       clock_halving_mode, hold_ack, sync_ready_input_r,
                       state_r != bus_pins_pkg::BUS_IDLE};
          bus_pins_pkg::COUNT_OFFSET:
            prdata <= {tmr_cnt_r[1], tmr_cnt_r[0]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ctrl_r <= bus_pins_pkg::CTRL_RESET;
      upper_base_r <= bus_pins_pkg::UPPER_BASE_RESET;
      upper_size_r <= bus_pins_pkg::UPPER_SIZE_RESET;
      tmr_cfg_r[0] <= bus_pins_pkg::TMR_RESET;
      tmr_cfg_r[1] <= bus_pins_pkg::TMR_RESET;
    end else if (apb_write) begin
      case (paddr)
        bus_pins_pkg::CTRL_OFFSET: ctrl_r <= pwdata[7:0];
        bus_pins_pkg::UPPER_OFFSET: begin
          upper_base_r <= pwdata[3:0];
          upper_size_r <= pwdata[5:4];
        end
        bus_pins_pkg::TMR0_OFFSET: tmr_cfg_r[0] <= pwdata;
        bus_pins_pkg::TMR1_OFFSET: tmr_cfg_r[1] <= pwdata;
        default: ;
      endcase
    end
  end

  // Sticky: once the bank is on, only reset brings the select back
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      bank1_on_r <= 1'b0;
    end else if (ctrl_r[bus_pins_pkg::CTRL_BANK1_BIT]) begin
      bank1_on_r <= 1'b1;
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  bus_pins_pkg::cycle_req_t cur_r;
  logic ready_now, drive_ok, in_upper, is_write;
  logic [3:0] size_mask;

  assign ready_now = sync_ready_input_r || async_ready_input_s_r[1];
  assign drive_ok = !hold_ack && !pin_isolation_mode;

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_r <= bus_pins_pkg::BUS_IDLE;
      cur_r <= '0;
      hold_ack <= 1'b0;
      cyc_ready <= 1'b0;
    end else begin
      cyc_ready <= (state_r == bus_pins_pkg::BUS_IDLE) && drive_ok &&
                   !hold_s_r[1] && strap_done_r &&
                   // Stays up until taken; a request may wait for a tick
                   !(bus_tick && cyc_valid && cyc_ready);
      if (bus_tick) begin
        case (state_r)
          bus_pins_pkg::BUS_IDLE: begin
            // Hold only taken between cycles
            hold_ack <= hold_s_r[1];
            if (cyc_valid && cyc_ready && !hold_s_r[1]) begin
              cur_r <= cyc_req;
              state_r <= bus_pins_pkg::BUS_T1;
            end
          end
          bus_pins_pkg::BUS_T1: state_r <= bus_pins_pkg::BUS_T2;
          bus_pins_pkg::BUS_T2: state_r <= bus_pins_pkg::BUS_T3;
          bus_pins_pkg::BUS_T3: begin
            if (ready_now) begin
              state_r <= bus_pins_pkg::BUS_T4;
            end
          end
          bus_pins_pkg::BUS_T4: state_r <= bus_pins_pkg::BUS_IDLE;
          default: state_r <= bus_pins_pkg::BUS_IDLE;
        endcase
      end
    end
  end

  // Block of 64K shifted left by size, up to 512K
  assign size_mask = 4'hf << upper_size_r;
  assign in_upper = ((cur_r.addr[19:16] ^ upper_base_r) & size_mask)
                    == 4'h0;
  assign is_write = (cur_r.kind == bus_pins_pkg::ST_MEM_WR) ||
                    (cur_r.kind == bus_pins_pkg::ST_IO_WR);

  // ==========================================================
  // Pin registers, one core cycle behind the sequencer state
  logic active, mem_kind;
  assign active = state_r != bus_pins_pkg::BUS_IDLE;
  assign mem_kind = cur_r.kind[2] && cur_r.kind != bus_pins_pkg::ST_PASSIVE;

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      bus_cycle_status <= bus_pins_pkg::ST_PASSIVE;
      bus_cycle_status_oe <= 1'b0;
      dma_cycle_flag <= 1'b0;
      dma_cycle_flag_oe <= 1'b0;
      upper_memory_select_n <= 1'b1;
      upper_memory_select_oe <= 1'b0;
      dram_bank1_row_strobe_n <= 1'b1;
      upper_zero_flag_n <= 1'b1;
      write_strobe_n <= 1'b1;
      high_byte_write_enable_n <= 1'b1;
      low_byte_write_enable_n <= 1'b1;
      strobe_oe <= 1'b0;
    end else begin
      bus_cycle_status_oe <= drive_ok;
      dma_cycle_flag_oe <= drive_ok;
      upper_memory_select_oe <= drive_ok;
      strobe_oe <= drive_ok;
      if (state_r inside {bus_pins_pkg::BUS_T1, bus_pins_pkg::BUS_T2,
                          bus_pins_pkg::BUS_T3}) begin
        bus_cycle_status <= cur_r.kind;
      end else begin
        bus_cycle_status <= bus_pins_pkg::ST_PASSIVE;
      end
      dma_cycle_flag <= cur_r.dma && active &&
                        state_r != bus_pins_pkg::BUS_T1;
      upper_zero_flag_n <= !(active &&
                             cur_r.addr[19:16] == 4'h0);
      upper_memory_select_n <= !(active && mem_kind && in_upper &&
                                 !bank1_on_r);
      dram_bank1_row_strobe_n <= !(active && mem_kind && in_upper &&
                                   bank1_on_r);
      write_strobe_n <= !(is_write &&
                          (state_r inside {bus_pins_pkg::BUS_T2,
                                           bus_pins_pkg::BUS_T3}));
      high_byte_write_enable_n <= cur_r.high_byte_enable_n ||
        !(is_write && (state_r inside {bus_pins_pkg::BUS_T2,
                                       bus_pins_pkg::BUS_T3}));
      low_byte_write_enable_n <= cur_r.addr[0] ||
        !(is_write && (state_r inside {bus_pins_pkg::BUS_T2,
                                       bus_pins_pkg::BUS_T3}));
    end
  end

  // ==========================================================
  // Timers; config word is period in low half, duty in high half
  logic [1:0] tin_pin;
  assign tin_pin = {timer1_input, timer0_input};

  for (genvar i = 0; i < 2; i++) begin : g_timer
    logic [1:0] tin_s_r;
    logic src, src_prev_r, rise, done_r, gpio_sel, ten, tcont;
    assign gpio_sel = (i == 0) ? ctrl_r[bus_pins_pkg::CTRL_GPIO11_BIT]
                               : ctrl_r[bus_pins_pkg::CTRL_GPIO0_BIT];
    assign ten = ctrl_r[bus_pins_pkg::CTRL_TEN_LSB + i];
    assign tcont = ctrl_r[bus_pins_pkg::CTRL_TCONT_LSB + i];
    assign src = ctrl_r[bus_pins_pkg::CTRL_PWD_BIT] ? pd_s_r[1]
               : (gpio_sel ? 1'b1 : tin_s_r[1]);
    assign rise = src && !src_prev_r;

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
        tin_s_r <= 2'h3;
        src_prev_r <= 1'b1;
      end else begin
        tin_s_r <= {tin_s_r[0], tin_pin[i]};
        src_prev_r <= src;
      end
    end

    always_ff @(posedge core_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
        tmr_cnt_r[i] <= 16'h0000;
        done_r <= 1'b0;
        timer_output[i] <= 1'b0;
        timer_output_oe[i] <= 1'b0;
      end else begin
        timer_output_oe[i] <= drive_ok;
        if (!ten) begin
          tmr_cnt_r[i] <= 16'h0000;
          done_r <= 1'b0;
          timer_output[i] <= 1'b0;
        end else begin
          if (rise) begin
            if (tmr_cnt_r[i] == tmr_cfg_r[i][15:0]) begin
              tmr_cnt_r[i] <= 16'h0000;
              done_r <= !tcont || done_r;
            end else begin
              tmr_cnt_r[i] <= tmr_cnt_r[i] + 16'h0001;
            end
          end
          if (tcont) begin
            timer_output[i] <= tmr_cnt_r[i] < tmr_cfg_r[i][31:16];
          end else begin
            timer_output[i] <= rise && !done_r &&
                               tmr_cnt_r[i] == tmr_cfg_r[i][15:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_cycle_start;
    state_r == bus_pins_pkg::BUS_T1;
  endsequence
  sequence s_status_shown;
    ##1 bus_cycle_status == $past(cur_r.kind);
  endsequence

  AST_STATUS_CODE: assert property (s_cycle_start |-> s_status_shown)
    else $error("status code differs from cycle kind");
  AST_STATUS_IDLE: assert property (
    $past(state_r) == bus_pins_pkg::BUS_IDLE && !$past(hold_ack, 2)
      |-> bus_cycle_status == bus_pins_pkg::ST_PASSIVE)
    else $error("idle bus not passive");
  AST_HOLD_FLOAT: assert property (
    $past(hold_ack) |-> !bus_cycle_status_oe && !dma_cycle_flag_oe &&
                        !strobe_oe && !upper_memory_select_oe)
    else $error("pin driven during hold");
  AST_DMA_FLAG: assert property (
    $past(state_r) == bus_pins_pkg::BUS_T2 && $past(cur_r.dma)
      |-> dma_cycle_flag)
    else $error("dma flag missing in t2");
  AST_DMA_T1: assert property (
    $past(state_r) == bus_pins_pkg::BUS_T1 |-> !dma_cycle_flag)
    else $error("dma flag in t1");
  AST_WAIT_READY: assert property (
    state_r == bus_pins_pkg::BUS_T3 && bus_tick && !ready_now
      |=> state_r == bus_pins_pkg::BUS_T3)
    else $error("left t3 without ready");
  AST_ISOLATE: assert property (
    pin_isolation_mode |-> ##2 !bus_cycle_status_oe && !strobe_oe &&
                           timer_output_oe == 2'h0)
    else $error("pin driven in isolation mode");
  AST_BANK1_STICKY: assert property (
    bank1_on_r |=> bank1_on_r ##1 upper_memory_select_n)
    else $error("upper select after bank1 enabled");
  AST_UZI: assert property (
    state_r == bus_pins_pkg::BUS_T1 && cur_r.addr[19:16] == 4'h0
      |=> !upper_zero_flag_n)
    else $error("upper zero flag missing");
  AST_WHB: assert property (
    !high_byte_write_enable_n |-> !write_strobe_n)
    else $error("high write enable without strobe");
  AST_WLB: assert property (
    !low_byte_write_enable_n |-> !write_strobe_n && !$past(cur_r.addr[0]))
    else $error("low write enable wrong");
  AST_TIMER_COUNT: assert property (
    g_timer[0].ten && $past(g_timer[0].ten) && $past(g_timer[0].rise) &&
    $past(tmr_cnt_r[0]) != $past(tmr_cfg_r[0][15:0])
      |-> tmr_cnt_r[0] == $past(tmr_cnt_r[0]) + 16'h0001)
    else $error("timer 0 did not advance");

endmodule // bus_pins
`default_nettype wire

// ==== verif/ext_mem_model.sv ====
// External memory model answering bus cycles on the two ready pins.
// Assumes bus_cycle_status leaves 111 while a cycle is in progress.
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model #(
  parameter int WAIT_CLKS = 3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic bus_clock_output,
  input wire logic [2:0] bus_cycle_status,
  input wire logic [1:0] ready_mode,
  output logic sync_ready_input,
  output logic async_ready_input
);
  logic bclk_q;
  int cnt;
  // ==========================================================
  // Wait count in bus clocks, aligned to the bus clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_q <= 1'b0;
      cnt <= 0;
    end else begin
      bclk_q <= bus_clock_output;
      if (bus_cycle_status == 3'h7)
        cnt <= 0;
      else if (bus_clock_output && !bclk_q)
        cnt <= cnt + 1;
    end
  end
  // Mode 0 ties sync ready high; slow modes stall whole bus clocks
  assign sync_ready_input = (ready_mode == 2'h0) ||
    (ready_mode == 2'h1 && cnt >= WAIT_CLKS);
  assign async_ready_input = ready_mode == 2'h2 && cnt >= WAIT_CLKS;
endmodule // ext_mem_model
`default_nettype wire

// ==== verif/test_bus_pins.sv ====
// Testbench of bus_pins: APB, bus cycles, ready, hold, timers, straps.
// Assumes the external memory model drives both ready pins.
`timescale 1ns/10ps
`default_nettype none
module test_bus_pins;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  bus_pins_pkg::cycle_req_t cyc_req;
  logic cyc_valid, cyc_ready, hold_request, hold_ack, er;
  logic sync_ready_input, async_ready_input, clock_halving_strap;
  logic isolation_request_a, isolation_request_b, timer0_input;
  logic timer1_input, pulse_demod_input, bus_clock_output;
  logic clock_halving_mode, pin_isolation_mode, bus_cycle_status_oe;
  logic [2:0] bus_cycle_status;
  logic dma_cycle_flag, dma_cycle_flag_oe, upper_memory_select_n;
  logic upper_memory_select_oe, dram_bank1_row_strobe_n;
  logic upper_zero_flag_n, high_byte_write_enable_n, strobe_oe;
  logic low_byte_write_enable_n, write_strobe_n;
  logic [1:0] timer_output, timer_output_oe, ready_mode;
  logic saw_dma, saw_wr, saw_ucs, saw_uzi, be_ok, dma_t1, wr_t1, saw_ras;
  int err_total, n_checks, len;
  wire [5:0] oes = {bus_cycle_status_oe, dma_cycle_flag_oe,
    upper_memory_select_oe, strobe_oe, timer_output_oe};

  bus_pins i_bus_pins (.core_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cyc_req, .cyc_valid,
    .cyc_ready, .hold_request, .hold_ack, .sync_ready_input,
    .async_ready_input, .clock_halving_strap, .isolation_request_a,
    .isolation_request_b, .timer0_input, .timer1_input,
    .pulse_demod_input, .bus_clock_output, .clock_halving_mode,
    .pin_isolation_mode, .bus_cycle_status, .bus_cycle_status_oe,
    .dma_cycle_flag, .dma_cycle_flag_oe, .upper_memory_select_n,
    .upper_memory_select_oe, .dram_bank1_row_strobe_n,
    .upper_zero_flag_n, .high_byte_write_enable_n,
    .low_byte_write_enable_n, .write_strobe_n, .strobe_oe,
    .timer_output, .timer_output_oe);
  ext_mem_model i_ext_mem_model (.core_clk, .reset_n, .bus_clock_output,
    .bus_cycle_status, .ready_mode, .sync_ready_input,
    .async_ready_input);

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rst(input logic h, input logic a, input logic b);
    @(posedge core_clk);
    reset_n <= 1'b0;
    clock_halving_strap <= h;
    isolation_request_a <= a;
    isolation_request_b <= b;
    repeat (5) @(posedge core_clk);
    chk(oes, 32'h0);
    reset_n <= 1'b1;
    repeat (12) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Records what the pins show over one whole bus cycle
  task automatic cyc(input logic [2:0] k, input logic [19:0] a,
                     input logic hb, input logic dm);
    int i;
    i = 0;
    do begin @(negedge core_clk); i++; end while (!cyc_ready && i < 50);
    @(posedge core_clk);
    cyc_req <= '{k, a, hb, dm};
    cyc_valid <= 1'b1;
    i = 0;
    do begin @(negedge core_clk); i++; end
      while (bus_cycle_status === 3'h7 && i < 50);
    dma_t1 = dma_cycle_flag;
    wr_t1 = write_strobe_n;
    len = 1;
    {saw_dma, saw_wr, be_ok, saw_ras} = 4'b0010;
    saw_ucs = upper_memory_select_n === 1'b0;
    saw_uzi = upper_zero_flag_n === 1'b0;
    @(posedge core_clk);
    cyc_valid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(negedge core_clk);
      if (bus_cycle_status === k) len++;
      if (dma_cycle_flag === 1'b1) saw_dma = 1'b1;
      if (upper_memory_select_n === 1'b0) saw_ucs = 1'b1;
      if (upper_zero_flag_n === 1'b0) saw_uzi = 1'b1;
      if (dram_bank1_row_strobe_n === 1'b0) saw_ras = 1'b1;
      if (write_strobe_n === 1'b0) begin
        saw_wr = 1'b1;
        if (high_byte_write_enable_n !== hb) be_ok = 1'b0;
        if (low_byte_write_enable_n !== a[0]) be_ok = 1'b0;
      end
    end
  endtask
  task automatic tpulse(input int sel, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (sel == 0) timer0_input <= 1'b0;
      else pulse_demod_input <= 1'b0;
      repeat (4) @(posedge core_clk);
      timer0_input <= 1'b1;
      pulse_demod_input <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task automatic bper(input int exp);
    time t0;
    @(posedge bus_clock_output);
    t0 = $time;
    @(posedge bus_clock_output);
    chk(32'(($time - t0) / 20), exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, bus_pins_pkg::UPPER_OFFSET, 32'h0);
    chk(rd, 32'h0000000f);
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 32'h1);
  endtask
  task automatic t_codes;
    logic [19:0] a;
    for (int k = 0; k < 7; k++) begin
      a = (k[1] ? 20'hf0000 : 20'h01230) | 20'(k[0]);
      cyc(k[2:0], a, k[1] ^ k[0], k[2] ^ k[0]);
      chk(len, 32'd6);
      chk(dma_t1, 32'h0);
      chk(saw_dma, 32'(k[2] ^ k[0]));
      chk(saw_wr, 32'(k == 2 || k == 6));
      chk(wr_t1, 32'h1);
      chk(be_ok, 32'h1);
      chk(saw_uzi, 32'(!k[1]));
      chk(saw_ucs, 32'(k == 6));
      chk(bus_cycle_status, 32'h7);
    end
  endtask
  task automatic t_ready;
    for (int m = 1; m < 3; m++) begin
      ready_mode <= 2'(m);
      cyc(3'h5, 20'h10000, 1'b1, 1'b0);
      chk(len > 6, 32'h1);
      chk(bus_cycle_status, 32'h7);
    end
    ready_mode <= 2'h0;
  endtask
  task automatic t_timer;
    apb(1'b1, bus_pins_pkg::TMR0_OFFSET, 32'h000000ff);
    apb(1'b1, bus_pins_pkg::TMR1_OFFSET, 32'h000000ff);
    apb(1'b1, bus_pins_pkg::CTRL_OFFSET, 32'h30);
    tpulse(0, 3);
    apb(1'b0, bus_pins_pkg::COUNT_OFFSET, 32'h0);
    chk(rd[15:0], 32'h3);
    apb(1'b1, bus_pins_pkg::CTRL_OFFSET, 32'h32);
    tpulse(0, 2);
    apb(1'b0, bus_pins_pkg::COUNT_OFFSET, 32'h0);
    chk(rd[15:0], 32'h3);
    apb(1'b1, bus_pins_pkg::CTRL_OFFSET, 32'h31);
    tpulse(1, 2);
    apb(1'b0, bus_pins_pkg::COUNT_OFFSET, 32'h0);
    chk(rd, 32'h00020005);
    apb(1'b1, bus_pins_pkg::TMR1_OFFSET, 32'h000300ff);
    apb(1'b1, bus_pins_pkg::CTRL_OFFSET, 32'hb1);
    repeat (2) @(posedge core_clk);
    chk(timer_output, 32'h2);
    tpulse(1, 1);
    repeat (2) @(posedge core_clk);
    chk(timer_output, 32'h0);
  endtask
  task automatic t_hold;
    int i;
    hold_request <= 1'b1;
    i = 0;
    do begin @(negedge core_clk); i++; end while (!hold_ack && i < 50);
    repeat (2) @(negedge core_clk);
    chk(oes, 32'h0);
    chk(cyc_ready, 32'h0);
    @(posedge core_clk);
    hold_request <= 1'b0;
    i = 0;
    do begin @(negedge core_clk); i++; end while (hold_ack && i < 50);
    repeat (2) @(negedge core_clk);
    chk(bus_cycle_status_oe, 32'h1);
  endtask
  task automatic t_upper;
    apb(1'b1, bus_pins_pkg::UPPER_OFFSET, 32'h38);
    cyc(3'h5, 20'hc0000, 1'b0, 1'b0);
    chk(saw_ucs, 32'h1);
    chk(saw_ras, 32'h0);
    cyc(3'h5, 20'h70000, 1'b0, 1'b0);
    chk(saw_ucs, 32'h0);
    // Enabling runs from code outside the upper block
    apb(1'b1, bus_pins_pkg::CTRL_OFFSET, 32'h08);
    cyc(3'h5, 20'hc0000, 1'b0, 1'b0);
    chk(saw_ucs, 32'h0);
    chk(saw_ras, 32'h1);
  endtask
  task automatic t_straps;
    bper(2);
    rst(1'b0, 1'b1, 1'b1);
    chk(clock_halving_mode, 32'h1);
    bper(4);
    rst(1'b1, 1'b0, 1'b0);
    chk(pin_isolation_mode, 32'h1);
    chk(oes, 32'h0);
  endtask

  // ==========================================================
  // Clock, watchdog, main sequence
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #(20 * 40000);
    err_total++;
    end_sim();
  end
  initial begin
    {reset_n, psel, penable, pwrite, cyc_valid, hold_request} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc_req = '0;
    ready_mode = 2'h0;
    {clock_halving_strap, isolation_request_a, isolation_request_b} = 3'h7;
    {timer0_input, timer1_input, pulse_demod_input} = 3'h7;
    err_total = 0;
    n_checks = 0;
    rst(1'b1, 1'b1, 1'b1);
    t_regs();
    t_codes();
    t_ready();
    t_timer();
    t_hold();
    t_upper();
    t_straps();
    end_sim();
  end
endmodule // test_bus_pins
`default_nettype wire
